/* hdl/dbm_pkg.sv */
package dbm_pkg;

    // ---------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [7:0] IDX_CTRL_ONE = 8'h20;
    localparam logic [7:0] IDX_STATUS = 8'h21;
    localparam logic [7:0] IDX_CTRL_TWO = 8'h22;
    localparam logic [7:0] IDX_TRACE = 8'h23;
    localparam logic [7:0] IDX_CTRL_A = 8'h24;
    localparam logic [7:0] IDX_CTRL_B = 8'h25;
    localparam logic [7:0] IDX_CTRL_C = 8'h26;
    localparam logic [7:0] IDX_ADDR_HIGH = 8'h29;
    localparam logic [7:0] IDX_ADDR_MID = 8'h2A;
    localparam logic [7:0] IDX_ADDR_LOW = 8'h2B;
    localparam logic [7:0] IDX_DATA_HIGH = 8'h2C;
    localparam logic [7:0] IDX_DATA_LOW = 8'h2D;
    localparam logic [7:0] IDX_HIGH_MASK = 8'h2E;
    localparam logic [7:0] IDX_LOW_MASK = 8'h2F;

    // ---------------------------------------------------------------
    // Field positions and codes
    // ---------------------------------------------------------------
    localparam int CTRL1_ARM = 7;
    localparam int CTRL1_FORCE_TRIGGER = 6;
    localparam int CTRL1_BRK = 4;
    localparam logic [1:0] VIEW_A = 2'h0;
    localparam logic [1:0] RNG_OFF = 2'h0;
    localparam logic [1:0] RNG_INSIDE = 2'h1;
    localparam logic [1:0] RNG_OUTSIDE = 2'h2;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [23:0] ADDR_RST = 24'h000000;
    localparam logic [31:0] RDATA_RST = 32'h00000000;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {SEQ_DISARMED, SEQ_WAIT, SEQ_FINAL} dbm_seq_t;

    typedef struct packed {
        logic size_qualify;
        logic sz;
        logic direction_qualify;
        logic rw;
        logic brk;
        logic tag;
        logic compe;
    } dbm_cmp_ctrl_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic word;
        logic fetch;
        logic [23:0] addr;
        logic [15:0] data;
    } dbm_cpu_bus_t;

    typedef struct packed {
        logic exec;
        logic flush;
        logic [23:0] addr;
    } dbm_exec_t;

endpackage

/* hdl/dbm_match_top.sv */
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/100ps
module dbm_match_top
    import dbm_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // CPU bus observation
    input wire dbm_cpu_bus_t cpu_bus_i,
    input wire dbm_exec_t cpu_exec_i,
    input wire logic background_debug_mode_i,
    input wire logic secure_i,
    // Debug results
    output logic [2:0] match_o,
    output logic break_req_o,
    output logic trace_force_trigger_o
);

    // ---------------------------------------------------------------
    // Reset release
    // ---------------------------------------------------------------
    logic [1:0] rst_sync_r;
    wire rst_n = rst_sync_r[1];

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    // ---------------------------------------------------------------
    // Helper functions
    // ---------------------------------------------------------------
    function automatic logic dir_ok(input dbm_cmp_ctrl_t c, input logic wr);
        dir_ok = !c.direction_qualify || (c.rw ? !wr : wr);
    endfunction

    function automatic logic size_ok(input dbm_cmp_ctrl_t c, input logic word);
        size_ok = !c.size_qualify || (c.sz ? !word : word);
    endfunction

    // ---------------------------------------------------------------
    // AHB-Lite front end
    // ---------------------------------------------------------------
    logic rd_pend_r;
    logic wr_pend_r;
    logic [7:0] rd_idx_r;
    logic [7:0] wr_idx_r;
    logic [31:0] hrdata_r;
    logic hready_r;
    logic hresp_r;

    wire take = hsel_i && htrans_i[1] && hready_i;
    wire [7:0] a_idx = haddr_i[9:2];

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend_r <= 1'b0;
            wr_pend_r <= 1'b0;
            rd_idx_r <= REG_RST;
            wr_idx_r <= REG_RST;
            hready_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            // One wait state on reads so a preceding write has landed
            rd_pend_r <= take && !hwrite_i;
            wr_pend_r <= take && hwrite_i;
            hready_r <= !(take && !hwrite_i);
            hresp_r <= 1'b0;
            if (take) begin
                rd_idx_r <= a_idx;
                wr_idx_r <= a_idx;
            end
        end
    end

    // ---------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------
    logic arm_r;
    logic brk_en_r;
    logic [1:0] view_r;
    logic [1:0] rng_r;
    logic [15:0] cdata_r;
    logic [15:0] mask_r;
    logic [15:0] trace_word_r;
    logic [2:0] cause_r;
    dbm_cmp_ctrl_t cmp_ctrl_r [3];
    logic [23:0] cmp_addr_r [3];
    dbm_seq_t seq_r;

    wire view_a = view_r == VIEW_A;
    wire wr_ctrl1 = wr_pend_r && wr_idx_r == IDX_CTRL_ONE;
    wire wr_ctrl2 = wr_pend_r && wr_idx_r == IDX_CTRL_TWO;
    wire force_trigger_w = wr_ctrl1 && hwdata_i[CTRL1_FORCE_TRIGGER];
    wire cfg_ok = wr_pend_r && !arm_r;
    wire wr_dh = cfg_ok && view_a && wr_idx_r == IDX_DATA_HIGH;
    wire wr_dl = cfg_ok && view_a && wr_idx_r == IDX_DATA_LOW;
    wire wr_mh = cfg_ok && view_a && wr_idx_r == IDX_HIGH_MASK;
    wire wr_ml = cfg_ok && view_a && wr_idx_r == IDX_LOW_MASK;
    wire seq_wait = seq_r == SEQ_WAIT;

    logic [2:0] hit_w;
    dbm_cmp_ctrl_t ca;
    dbm_cmp_ctrl_t cb;
    assign ca = cmp_ctrl_r[0];
    assign cb = cmp_ctrl_r[1];

    // Hits only matter while waiting; a forced trigger counts only in SEQ_WAIT
    wire go_final = seq_wait && ((|hit_w) || force_trigger_w);
    wire [2:0] brk_bits = {cmp_ctrl_r[2].brk, cb.brk, ca.brk};
    wire brk_nxt = go_final && (force_trigger_w ? brk_en_r : |(hit_w & brk_bits));
    wire trace_nxt = go_final && !secure_i;

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            arm_r <= 1'b0;
            brk_en_r <= 1'b0;
            view_r <= 2'b00;
            rng_r <= RNG_OFF;
        end else begin
            // Reaching final disarms; that clear outranks a same-cycle write
            if (go_final) begin
                arm_r <= 1'b0;
            end else if (wr_ctrl1) begin
                arm_r <= hwdata_i[CTRL1_ARM];
            end
            if (wr_ctrl1) begin
                brk_en_r <= hwdata_i[CTRL1_BRK];
                view_r <= hwdata_i[1:0];
            end
            if (wr_ctrl2 && !arm_r) begin
                rng_r <= hwdata_i[1:0];
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cdata_r <= WORD_RST;
            mask_r <= WORD_RST;
        end else begin
            if (wr_dh) cdata_r[15:8] <= hwdata_i[7:0];
            if (wr_dl) cdata_r[7:0] <= hwdata_i[7:0];
            if (wr_mh) mask_r[15:8] <= hwdata_i[7:0];
            if (wr_ml) mask_r[7:0] <= hwdata_i[7:0];
        end
    end

    // ---------------------------------------------------------------
    // Comparators A, B, C
    // ---------------------------------------------------------------
    logic [2:0] fhit;
    logic [2:0] thit;
    logic [2:0] tag_vld_r;

    wire bus_on = cpu_bus_i.valid && !background_debug_mode_i;
    wire exec_on = cpu_exec_i.exec && !background_debug_mode_i;
    // Masked XOR: any checked bit that differs blocks the match
    wire data_eq = ((cpu_bus_i.data ^ cdata_r) & mask_r) == WORD_RST;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_cmp
            wire wr_c = cfg_ok && wr_idx_r == IDX_CTRL_A + 8'(gi);
            wire wr_sel = cfg_ok && view_r == 2'(gi);
            wire aeq = cpu_bus_i.addr == cmp_addr_r[gi];
            wire szq = (gi == 2) || size_ok(cmp_ctrl_r[gi], cpu_bus_i.word);
            wire dtq = (gi != 0) || data_eq;
            wire on = bus_on && cmp_ctrl_r[gi].compe;
            wire tset = on && cmp_ctrl_r[gi].tag && cpu_bus_i.fetch && aeq;

            always_ff @(posedge core_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    cmp_ctrl_r[gi] <= '0;
                    cmp_addr_r[gi] <= ADDR_RST;
                end else begin
                    if (wr_c) cmp_ctrl_r[gi] <= hwdata_i[6:0];
                    if (wr_sel && wr_idx_r == IDX_ADDR_HIGH) cmp_addr_r[gi][23:16] <= hwdata_i[7:0];
                    if (wr_sel && wr_idx_r == IDX_ADDR_MID) cmp_addr_r[gi][15:8] <= hwdata_i[7:0];
                    if (wr_sel && wr_idx_r == IDX_ADDR_LOW) cmp_addr_r[gi][7:0] <= hwdata_i[7:0];
                end
            end

            // Forced: fires on the access itself, opcode fetches included
            assign fhit[gi] = on && !cmp_ctrl_r[gi].tag && aeq && dir_ok(cmp_ctrl_r[gi], cpu_bus_i.write)
                && szq && dtq;

            // Tagged: fetch marks the opcode, execution of it fires
            assign thit[gi] = exec_on && cmp_ctrl_r[gi].compe && cmp_ctrl_r[gi].tag && tag_vld_r[gi]
                && cpu_exec_i.addr == cmp_addr_r[gi];

            always_ff @(posedge core_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    tag_vld_r[gi] <= 1'b0;
                end else if (tset) begin
                    tag_vld_r[gi] <= 1'b1;
                end else if (cpu_exec_i.flush || thit[gi]) begin
                    tag_vld_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // Range logic on the A/B pair
    // ---------------------------------------------------------------
    // Range uses A's direction and data qualifiers; sizes are ignored
    wire rng_on = rng_r != RNG_OFF && ca.compe && cb.compe;
    wire ge_a = cpu_bus_i.addr >= cmp_addr_r[0];
    wire le_b = cpu_bus_i.addr <= cmp_addr_r[1];
    wire in_rng = rng_r == RNG_INSIDE ? (ge_a && le_b) : (!ge_a || !le_b);
    wire rng_hit = bus_on && !ca.tag && in_rng && dir_ok(ca, cpu_bus_i.write) && data_eq;

    assign hit_w[0] = rng_on ? rng_hit : (fhit[0] || thit[0]);
    assign hit_w[1] = !rng_on && (fhit[1] || thit[1]);
    assign hit_w[2] = fhit[2] || thit[2];

    // ---------------------------------------------------------------
    // Sequencer and outputs
    // ---------------------------------------------------------------
    logic [2:0] match_r;
    logic brk_r;
    logic trace_r;

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            seq_r <= SEQ_DISARMED;
            match_r <= 3'b000;
            brk_r <= 1'b0;
            trace_r <= 1'b0;
            cause_r <= 3'b000;
            trace_word_r <= WORD_RST;
        end else begin
            // Hits outside the waiting state are dropped, never re-evaluated
            match_r <= hit_w & {3{seq_wait}};
            brk_r <= brk_nxt;
            trace_r <= trace_nxt;
            case (seq_r)
                SEQ_DISARMED: if (arm_r) seq_r <= SEQ_WAIT;
                SEQ_WAIT: begin
                    if (go_final) begin
                        seq_r <= SEQ_FINAL;
                    end else if (!arm_r) begin
                        seq_r <= SEQ_DISARMED;
                    end
                end
                SEQ_FINAL: seq_r <= SEQ_DISARMED;
                default: seq_r <= SEQ_DISARMED;
            endcase
            if (seq_r == SEQ_DISARMED && arm_r) begin
                cause_r <= 3'b000;
            end else if (go_final) begin
                cause_r <= hit_w;
            end
            if (trace_nxt) begin
                trace_word_r <= cpu_bus_i.data;
            end
        end
    end

    // ---------------------------------------------------------------
    // Read decode
    // ---------------------------------------------------------------
    wire [23:0] view_addr = view_r == 2'h3 ? ADDR_RST : cmp_addr_r[view_r];
    wire [7:0] stat = {1'b0, cause_r, 1'b0, seq_r == SEQ_FINAL, seq_wait, arm_r};
    wire [7:0] ctrl1 = {arm_r, 1'b0, 1'b0, brk_en_r, 2'b00, view_r};
    wire [7:0] rd_cmp = rd_idx_r == IDX_CTRL_A ? {1'b0, ca}
        : rd_idx_r == IDX_CTRL_B ? {1'b0, cb}
        : rd_idx_r == IDX_CTRL_C ? {1'b0, cmp_ctrl_r[2]} : REG_RST;
    wire [7:0] rd_adr = rd_idx_r == IDX_ADDR_HIGH ? view_addr[23:16]
        : rd_idx_r == IDX_ADDR_MID ? view_addr[15:8]
        : rd_idx_r == IDX_ADDR_LOW ? view_addr[7:0] : REG_RST;
    wire [7:0] rd_dat = !view_a ? REG_RST
        : rd_idx_r == IDX_DATA_HIGH ? cdata_r[15:8]
        : rd_idx_r == IDX_DATA_LOW ? cdata_r[7:0]
        : rd_idx_r == IDX_HIGH_MASK ? mask_r[15:8]
        : rd_idx_r == IDX_LOW_MASK ? mask_r[7:0] : REG_RST;
    wire [15:0] rd_misc = rd_idx_r == IDX_CTRL_ONE ? {8'h00, ctrl1}
        : rd_idx_r == IDX_STATUS ? {8'h00, stat}
        : rd_idx_r == IDX_CTRL_TWO ? {14'h0000, rng_r}
        : rd_idx_r == IDX_TRACE ? trace_word_r : WORD_RST;
    wire [31:0] rd_word = {16'h0000, rd_misc | {8'h00, rd_cmp | rd_adr | rd_dat}};

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_r <= RDATA_RST;
        end else if (rd_pend_r) begin
            hrdata_r <= rd_word;
        end
    end

    assign hrdata_o = hrdata_r;
    assign hreadyout_o = hready_r;
    assign hresp_o = hresp_r;
    assign match_o = match_r;
    assign break_req_o = brk_r;
    assign trace_force_trigger_o = trace_r;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb_main @(posedge core_clk_i); endclocking
    default disable iff (!rst_n);

    a_mask_data_match: assert property (match_r[0] && $past(rng_r == RNG_OFF) && !$past(thit[0])
        |-> ((($past(cpu_bus_i.data) ^ $past(cdata_r)) & $past(mask_r)) == 16'h0000 && !$past(ca.tag)))
        else $error("comparator A matched with a masked data difference");
    a_mask_write_gate: assert property ($changed(mask_r) || $changed(cdata_r)
        |-> $past(!arm_r && view_r == VIEW_A))
        else $error("data or mask changed while armed or wrong view");
    a_secure_no_trace: assert property (trace_force_trigger_o |-> !$past(secure_i))
        else $error("trace triggered in secure mode");
    a_disarmed_quiet: assert property ($past(seq_r) != SEQ_WAIT
        |-> !break_req_o && !trace_force_trigger_o && match_o == 3'b000)
        else $error("debug output while not armed");
    a_final_entry: assert property (seq_r == SEQ_FINAL && !$past(secure_i)
        |-> trace_force_trigger_o ##1 seq_r == SEQ_DISARMED)
        else $error("final state without trace trigger or no return");
    a_force_force_trigger: assert property (force_trigger_w && seq_wait
        |=> seq_r == SEQ_FINAL && !arm_r && break_req_o == $past(brk_en_r))
        else $error("force trigger did not reach final");
    a_bdm_blocks: assert property ($past(background_debug_mode_i) |-> match_o == 3'b000)
        else $error("match during background debug mode");
    a_dir_qualify: assert property (match_r[2] && !$past(thit[2]) && $past(cmp_ctrl_r[2].direction_qualify)
        |-> $past(cpu_bus_i.write) == !$past(cmp_ctrl_r[2].rw))
        else $error("comparator C ignored the direction select");
    a_exact_addr: assert property (match_r[1] && !$past(thit[1])
        |-> $past(cpu_bus_i.addr) == $past(cmp_addr_r[1]))
        else $error("comparator B matched without exact address");
    a_range_remap: assert property ($past(rng_on) |-> !match_o[1])
        else $error("match 1 driven in range mode");
    a_cause_hold: assert property (seq_r == SEQ_FINAL |=> $stable(cause_r))
        else $error("captured match cause changed after final");
    a_tag_exec: assert property (match_r[0] && $past(ca.tag) && !$past(rng_on)
        |-> $past(cpu_exec_i.exec) && $past(cpu_exec_i.addr) == $past(cmp_addr_r[0]))
        else $error("tagged match without execution of the tagged opcode");

    c_forced_final: cover property (seq_wait && fhit[2] ##1 seq_r == SEQ_FINAL);
    c_tagged_final: cover property (seq_wait && thit[0] ##1 seq_r == SEQ_FINAL ##0 break_req_o);
    c_range_final: cover property (seq_wait && rng_on && rng_hit ##1 match_o[0]);
    c_force_trigger_secure: cover property (force_trigger_w && seq_wait && secure_i ##1 !trace_force_trigger_o);

endmodule // dbm_match_top

/* tb/dbm_cpu_model.sv */
`timescale 1ns/100ps
module dbm_cpu_model
    import dbm_pkg::*;
(
    // Clock
    input wire logic core_clk_i,
    // CPU bus activity seen by the block
    output dbm_cpu_bus_t cpu_bus_o,
    output dbm_exec_t cpu_exec_o
);
    initial begin
        cpu_bus_o = '0;
        cpu_exec_o = '0;
    end

    // ---------------------------------------------------------------
    // Bus cycles
    // ---------------------------------------------------------------
    // Released lines show the inverse, so a stale value can never match by luck
    task automatic cycle(input logic w, input logic wd, input logic f, input logic [23:0] a,
        input logic [15:0] d, input int gap);
        @(posedge core_clk_i);
        cpu_bus_o <= '{1'b1, w, wd, f, a, d};
        @(posedge core_clk_i);
        cpu_bus_o <= '{1'b0, ~w, ~wd, ~f, ~a, ~d};
        repeat (gap) @(posedge core_clk_i);
    endtask

    // Opcode entering execution, or the queue being flushed
    task automatic pipe(input logic ex, input logic fl, input logic [23:0] a);
        @(posedge core_clk_i);
        cpu_exec_o <= '{ex, fl, a};
        @(posedge core_clk_i);
        cpu_exec_o <= '{1'b0, 1'b0, ~a};
        repeat (3) @(posedge core_clk_i);
    endtask
endmodule // dbm_cpu_model

/* tb/test_dbm_match_top.sv */
`timescale 1ns/100ps
module test_dbm_match_top;
    import dbm_pkg::*;
    logic core_clk_i, arst_n_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o;
    logic background_debug_mode_i, secure_i, break_req_o, trace_force_trigger_o, rd_pend;
    logic [31:0] haddr_i, hwdata_i, hrdata_o;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i, match_o;
    logic [15:0] lfsr;
    dbm_cpu_bus_t cpu_bus_i;
    dbm_exec_t cpu_exec_i;
    int mismatches, check_count, cycles;
    logic [7:0] rq[$];
    logic [4:0] ev;
    logic [4:0] eq[$];

    assign hready_i = hreadyout_o;

    dbm_match_top dbm_match_top_inst (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
        .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .cpu_bus_i(cpu_bus_i), .cpu_exec_i(cpu_exec_i), .background_debug_mode_i(background_debug_mode_i),
        .secure_i(secure_i), .match_o(match_o), .break_req_o(break_req_o), .trace_force_trigger_o(trace_force_trigger_o));

    dbm_cpu_model dbm_cpu_model_inst (.core_clk_i(core_clk_i), .cpu_bus_o(cpu_bus_i), .cpu_exec_o(cpu_exec_i));

    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [15:0] nxt();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Single word transfer; the address phase is held until hready is seen high
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge core_clk_i);
        htrans_i <= 2'h2;
        hwrite_i <= w;
        haddr_i <= {22'h0, idx, 2'h0};
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= {24'h0, d};
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        rq.push_back(exp);
        bus(1'b0, idx, 8'h00);
    endtask

    // Disarm first, since armed writes to control and address are refused
    task automatic arm(input int c, input logic [7:0] ctl, input logic [23:0] a);
        wr(IDX_CTRL_ONE, {6'h04, 2'(c)});
        for (int i = 0; i < 3; i++) wr(8'(IDX_CTRL_A + i), (i == c) ? ctl : 8'h00);
        wr(IDX_ADDR_HIGH, a[23:16]);
        wr(IDX_ADDR_MID, a[15:8]);
        wr(IDX_ADDR_LOW, a[7:0]);
        wr(IDX_CTRL_ONE, {6'h24, 2'(c)});
        repeat (2) @(posedge core_clk_i);
    endtask

    task automatic hit(input logic w, input logic wd, input logic f, input logic [23:0] a,
        input logic [15:0] d, input logic [2:0] m);
        if (m !== 3'h0) eq.push_back({m, 1'b1, ~secure_i});
        dbm_cpu_model_inst.cycle(w, wd, f, a, d, 4);
    endtask

    // ---------------------------------------------------------------
    // Result watcher
    // ---------------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (rd_pend === 1'b1 && hreadyout_o === 1'b1) begin
            chk("hrdata", {24'h0, rq.pop_front()}, hrdata_o);
            chk("hresp", 32'h0, {31'h0, hresp_o});
            rd_pend = 1'b0;
        end
        if (htrans_i[1] && hready_i === 1'b1 && !hwrite_i) rd_pend = 1'b1;
        if (|{match_o, break_req_o, trace_force_trigger_o}) begin
            ev = (eq.size() > 0) ? eq.pop_front() : 5'h00;
            chk("event", {27'h0, ev}, {27'h0, match_o, break_req_o, trace_force_trigger_o});
        end
        // Timeout last, so nothing in this process runs after the end
        cycles++;
        if (cycles > 20000) begin
            mismatches++;
            close_out();
        end
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        logic [15:0] m, c, d;
        {arst_n_i, hwrite_i, background_debug_mode_i, secure_i, rd_pend} = '0;
        {haddr_i, hwdata_i, htrans_i} = '0;
        hsel_i = 1'b1;
        hsize_i = 3'h2;
        lfsr = 16'h5A82;
        repeat (4) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        rd(IDX_HIGH_MASK, 8'h00);
        rd(IDX_LOW_MASK, 8'h00);
        wr(IDX_CTRL_TWO, 8'h00);
        wr(IDX_HIGH_MASK, 8'hA5);
        wr(IDX_CTRL_ONE, 8'h11);
        rd(IDX_HIGH_MASK, 8'h00);
        wr(IDX_HIGH_MASK, 8'h3C);
        wr(IDX_CTRL_ONE, 8'h90);
        wr(IDX_HIGH_MASK, 8'h0F);
        wr(IDX_CTRL_ONE, 8'h10);
        rd(IDX_HIGH_MASK, 8'hA5);
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            m = nxt();
            c = nxt();
            d = c ^ (nxt() & ~m);
            if (i % 2 == 1) d = d ^ (m & (~m + 16'h1));
            wr(IDX_CTRL_ONE, 8'h10);
            wr(IDX_DATA_HIGH, c[15:8]);
            wr(IDX_DATA_LOW, c[7:0]);
            wr(IDX_HIGH_MASK, m[15:8]);
            wr(IDX_LOW_MASK, m[7:0]);
            arm(0, 8'h05, {8'h00, nxt() & 16'hFFFE});
            hit(1'b1, 1'b1, 1'b0, {8'h00, lfsr & 16'hFFFE}, d, (((d ^ c) & m) == 16'h0) ? 3'h1 : 3'h0);
        end
        $display("test data masks done");
        for (int k = 0; k < 8; k++) begin
            arm(2, {3'b011, k[2], k[1], 3'b101}, 24'h012340);
            hit(k[0], 1'b1, 1'b0, 24'h012340, 16'h0, (!k[2] || (k[1] == !k[0])) ? 3'h4 : 3'h0);
        end
        $display("test direction done");
        arm(1, 8'h65, 24'h020010);
        hit(1'b1, 1'b1, 1'b0, 24'h020010, 16'h0, 3'h0);
        hit(1'b1, 1'b0, 1'b0, 24'h020010, 16'h0, 3'h2);
        arm(2, 8'h05, 24'h001235);
        hit(1'b0, 1'b1, 1'b0, 24'h001234, 16'h0, 3'h0);
        background_debug_mode_i <= 1'b1;
        hit(1'b0, 1'b0, 1'b0, 24'h001235, 16'h0, 3'h0);
        background_debug_mode_i <= 1'b0;
        secure_i <= 1'b1;
        @(posedge core_clk_i);
        hit(1'b0, 1'b0, 1'b0, 24'h001235, 16'h0, 3'h4);
        secure_i <= 1'b0;
        $display("test exact address done");
        arm(2, 8'h05, 24'h003000);
        eq.push_back(5'b00011);
        wr(IDX_CTRL_ONE, 8'hD2);
        repeat (4) @(posedge core_clk_i);
        hit(1'b0, 1'b0, 1'b0, 24'h003000, 16'h0, 3'h0);
        $display("test force trigger done");
        arm(0, 8'h7F, 24'h004002);
        hit(1'b1, 1'b1, 1'b1, 24'h004002, 16'hFFFF, 3'h0);
        eq.push_back(5'b00111);
        dbm_cpu_model_inst.pipe(1'b1, 1'b0, 24'h004002);
        arm(0, 8'h7F, 24'h004002);
        hit(1'b0, 1'b1, 1'b1, 24'h004002, 16'h0, 3'h0);
        dbm_cpu_model_inst.pipe(1'b0, 1'b1, 24'h004002);
        dbm_cpu_model_inst.pipe(1'b1, 1'b0, 24'h004002);
        arm(0, 8'h05, 24'h004000);
        wr(IDX_CTRL_ONE, 8'h10);
        wr(IDX_HIGH_MASK, 8'h00);
        wr(IDX_LOW_MASK, 8'h00);
        wr(IDX_CTRL_ONE, 8'h90);
        repeat (2) @(posedge core_clk_i);
        hit(1'b0, 1'b1, 1'b1, 24'h004000, 16'h1234, 3'h1);
        $display("test opcode match done");
        arm(1, 8'h05, 24'h005100);
        arm(0, 8'h05, 24'h005000);
        wr(IDX_CTRL_ONE, 8'h10);
        wr(IDX_CTRL_B, 8'h05);
        wr(IDX_CTRL_TWO, 8'h01);
        wr(IDX_CTRL_ONE, 8'h90);
        repeat (2) @(posedge core_clk_i);
        hit(1'b1, 1'b1, 1'b0, 24'h005100, 16'h0, 3'h1);
        wr(IDX_CTRL_TWO, 8'h02);
        wr(IDX_CTRL_ONE, 8'h90);
        repeat (2) @(posedge core_clk_i);
        hit(1'b0, 1'b0, 1'b0, 24'h005000, 16'h0, 3'h0);
        hit(1'b0, 1'b0, 1'b0, 24'h004FFF, 16'h00C3, 3'h1);
        rd(IDX_TRACE, 8'hC3);
        rd(IDX_STATUS, 8'h10);
        rd(IDX_CTRL_TWO, 8'h02);
        $display("test range done");
        repeat (10) @(posedge core_clk_i);
        chk("pending", 32'h0, eq.size() + rq.size());
        close_out();
    end
endmodule // test_dbm_match_top
